// file: common/exec_pkg.sv
package exec_pkg;
	// =====================================================================
	// Widths
	localparam int DATA_W = 8;
	localparam int FADDR_W = 5;
	localparam int INSTR_W = 12;
	localparam int PC_W = 11;
	localparam int JUMP_W = 9;

	// =====================================================================
	// Instruction field positions
	localparam int DEST_BIT = 5;
	localparam int LIT_LSB = 0;

	// =====================================================================
	// Opcode patterns: an instruction matches when (instr & mask) == value
	localparam logic [11:0] MASK_FILE_D = 12'hfc0;
	localparam logic [11:0] MASK_FILE = 12'hfe0;
	localparam logic [11:0] MASK_JUMP = 12'he00;
	localparam logic [11:0] MASK_LIT = 12'hf00;
	localparam logic [11:0] CODE_CLR = 12'h060;
	localparam logic [11:0] CODE_COM = 12'h240;
	localparam logic [11:0] CODE_DEC = 12'h0c0;
	localparam logic [11:0] CODE_DECSZ = 12'h2c0;
	localparam logic [11:0] CODE_INC = 12'h280;
	localparam logic [11:0] CODE_INCSZ = 12'h3c0;
	localparam logic [11:0] CODE_JUMP = 12'ha00;
	localparam logic [11:0] CODE_IOR = 12'hd00;

	// =====================================================================
	// Status bits copied into the upper program counter on a jump
	localparam int STATUS_PAGE_LO = 5;
	localparam int STATUS_PAGE_HI = 6;

	// =====================================================================
	// Values
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ONE_BYTE = 8'h01;
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic [4:0] FADDR_RESET = 5'h00;
	localparam logic [10:0] PC_RESET = 11'h000;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_CLR = 4'h1,
		OP_COM = 4'h2,
		OP_DEC = 4'h3,
		OP_DECSZ = 4'h4,
		OP_JUMP = 4'h5,
		OP_INC = 4'h6,
		OP_INCSZ = 4'h7,
		OP_IOR = 4'h8
	} op_t;

	typedef enum logic {
		ST_EXEC = 1'b0,
		ST_FLUSH = 1'b1
	} exec_state_t;
endpackage

// file: common/alu_if.sv
`timescale 1ns/10ps
interface alu_if;
	import exec_pkg::*;
	op_t op;
	logic [7:0] file_val;
	logic [7:0] w_val;
	logic [7:0] literal;
	logic [7:0] result;
	logic zero;

	modport alu (input op, input file_val, input w_val, input literal, output result, output zero);
	modport ctl (output op, output file_val, output w_val, output literal, input result, input zero);
endinterface

// file: rtl/byte_op_alu.sv
`timescale 1ns/10ps
module byte_op_alu import exec_pkg::*; (
	alu_if.alu bus
);
	// =====================================================================
	// Result datapath
	always_comb begin
		case (bus.op)
			OP_CLR: bus.result = ZERO_BYTE; // see RQ1
			OP_COM: bus.result = ~bus.file_val; // see RQ3
			OP_DEC, OP_DECSZ: bus.result = bus.file_val - ONE_BYTE; // see RQ4 // see RQ5
			OP_INC, OP_INCSZ: bus.result = bus.file_val + ONE_BYTE; // see RQ9 // see RQ10
			OP_IOR: bus.result = bus.w_val | bus.literal; // see RQ11
			default: bus.result = ZERO_BYTE;
		endcase
	end

	assign bus.zero = (bus.result == ZERO_BYTE); // see RQ12
endmodule // byte_op_alu

// file: rtl/byte_op_branch_execute.sv
// Function
// RQ1: Clear writes 00h to the file register and always sets zero flag.
// RQ2: Destination bit 0 sends result to W, 1 writes file register back.
// RQ3: Complement inverts file register value into destination, updates zero flag.
// RQ4: Decrement subtracts one modulo 256 into destination, updates zero flag.
// RQ5: Decrement-skip writes f-1 to destination, skips on zero, flags untouched.
// RQ6: A taken skip discards the prefetched word, giving a two-cycle instruction.
// RQ7: Jump loads 9-bit literal into PC<8:0>, status<6:5> into PC<10:9>.
// RQ8: Jump takes two cycles, discards prefetched word, flags untouched.
// RQ9: Increment adds one modulo 256 into destination, updates zero flag.
// RQ10: Increment-skip writes f+1 to destination, skips on zero, flags untouched.
// RQ11: Literal-OR puts W OR literal into W, updates zero flag.
// RQ12: Zero flag updating ops except clear set it exactly when result is zero.
// RQ13: Non-skipping ops of this group other than jump finish in one cycle, no discard.
`timescale 1ns/10ps
module byte_op_branch_execute import exec_pkg::*; (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic instr_valid,
	input wire logic [11:0] instr,
	output logic [4:0] file_rd_addr,
	input wire logic [7:0] file_rd_data,
	input wire logic [7:0] status_in,
	output logic [7:0] w_out,
	output logic file_wr_en,
	output logic [4:0] file_wr_addr,
	output logic [7:0] file_wr_data,
	output logic z_wr_en,
	output logic z_value,
	output logic pc_load,
	output logic [10:0] pc_target,
	output logic discard_active
);

	// =====================================================================
	// Decode
	function automatic op_t decode_op(input logic [11:0] word);
		op_t op;
		op = OP_NONE;
		if ((word & MASK_FILE) == CODE_CLR) begin
			op = OP_CLR;
		end else if ((word & MASK_FILE_D) == CODE_COM) begin
			op = OP_COM;
		end else if ((word & MASK_FILE_D) == CODE_DEC) begin
			op = OP_DEC;
		end else if ((word & MASK_FILE_D) == CODE_DECSZ) begin
			op = OP_DECSZ;
		end else if ((word & MASK_FILE_D) == CODE_INC) begin
			op = OP_INC;
		end else if ((word & MASK_FILE_D) == CODE_INCSZ) begin
			op = OP_INCSZ;
		end else if ((word & MASK_JUMP) == CODE_JUMP) begin
			op = OP_JUMP;
		end else if ((word & MASK_LIT) == CODE_IOR) begin
			op = OP_IOR;
		end
		return op;
	endfunction

	function automatic logic is_skip_op(input op_t op);
		return (op == OP_DECSZ) || (op == OP_INCSZ);
	endfunction

	// Read-modify ops that honour the destination bit
	function automatic logic has_dest(input op_t op);
		return (op == OP_COM) || (op == OP_DEC) || (op == OP_INC) || (op == OP_DECSZ) || (op == OP_INCSZ);
	endfunction

	// =====================================================================
	// State
	exec_state_t state_q, state_d;
	logic [7:0] w_q, w_d;
	logic file_wr_en_q, file_wr_en_d;
	logic [4:0] file_wr_addr_q, file_wr_addr_d;
	logic [7:0] file_wr_data_q, file_wr_data_d;
	logic z_wr_en_q, z_wr_en_d;
	logic z_value_q, z_value_d;
	logic pc_load_q, pc_load_d;
	logic [10:0] pc_target_q, pc_target_d;
	op_t cur_op;
	logic executing;
	logic dest_file;

	// =====================================================================
	// Datapath
	alu_if alu_bus ();

	byte_op_alu alu_inst (
		.bus(alu_bus)
	);

	// Prefetched word arriving in the flush cycle is dropped, acting as a no-op
	assign executing = instr_valid && (state_q == ST_EXEC); // see RQ6 // see RQ8
	assign cur_op = executing ? decode_op(instr) : OP_NONE;
	assign dest_file = instr[DEST_BIT];
	assign file_rd_addr = instr[FADDR_W-1:0];

	assign alu_bus.op = cur_op;
	assign alu_bus.file_val = file_rd_data;
	assign alu_bus.w_val = w_q;
	assign alu_bus.literal = instr[LIT_LSB +: DATA_W];

	// =====================================================================
	// Sequencing: discard cycle and jump target
	always_comb begin
		state_d = ST_EXEC;
		pc_load_d = 1'b0;
		pc_target_d = pc_target_q;
		case (cur_op)
			OP_DECSZ, OP_INCSZ: begin
				// Skip only on a zero result; the prefetched word becomes a no-op
				if (is_skip_op(cur_op) && alu_bus.zero) begin
					state_d = ST_FLUSH; // see RQ5 // see RQ10 // see RQ6
				end
			end
			OP_JUMP: begin
				pc_load_d = 1'b1;
				pc_target_d = {status_in[STATUS_PAGE_HI:STATUS_PAGE_LO], instr[JUMP_W-1:0]}; // see RQ7
				state_d = ST_FLUSH; // see RQ8
			end
			default: begin
				state_d = ST_EXEC; // see RQ13
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_q <= ST_EXEC;
			pc_load_q <= 1'b0;
			pc_target_q <= PC_RESET;
		end else begin
			state_q <= state_d;
			pc_load_q <= pc_load_d;
			pc_target_q <= pc_target_d;
		end
	end

	// =====================================================================
	// Working register
	always_comb begin
		w_d = w_q;
		if (cur_op == OP_IOR) begin
			w_d = alu_bus.result; // see RQ11
		end else if (has_dest(cur_op) && !dest_file) begin
			w_d = alu_bus.result; // see RQ2
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			w_q <= W_RESET;
		end else begin
			w_q <= w_d;
		end
	end

	// =====================================================================
	// File register write-back
	always_comb begin
		file_wr_en_d = 1'b0;
		file_wr_addr_d = file_wr_addr_q;
		file_wr_data_d = file_wr_data_q;
		if ((cur_op == OP_CLR) || (has_dest(cur_op) && dest_file)) begin
			file_wr_en_d = 1'b1; // see RQ1 // see RQ2
			file_wr_addr_d = instr[FADDR_W-1:0];
			file_wr_data_d = alu_bus.result;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			file_wr_en_q <= 1'b0;
			file_wr_addr_q <= FADDR_RESET;
			file_wr_data_q <= ZERO_BYTE;
		end else begin
			file_wr_en_q <= file_wr_en_d;
			file_wr_addr_q <= file_wr_addr_d;
			file_wr_data_q <= file_wr_data_d;
		end
	end

	// =====================================================================
	// Zero flag update
	always_comb begin
		z_wr_en_d = 1'b0;
		z_value_d = z_value_q;
		case (cur_op)
			OP_CLR: begin
				z_wr_en_d = 1'b1;
				z_value_d = 1'b1; // see RQ1
			end
			OP_COM, OP_DEC, OP_INC, OP_IOR: begin
				z_wr_en_d = 1'b1; // see RQ3 // see RQ4 // see RQ9 // see RQ11
				z_value_d = alu_bus.zero; // see RQ12
			end
			default: begin
				// Skips and jumps leave every flag as it was
				z_wr_en_d = 1'b0; // see RQ5 // see RQ8 // see RQ10
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			z_wr_en_q <= 1'b0;
			z_value_q <= 1'b0;
		end else begin
			z_wr_en_q <= z_wr_en_d;
			z_value_q <= z_value_d;
		end
	end

	// =====================================================================
	// Outputs
	assign w_out = w_q;
	assign file_wr_en = file_wr_en_q;
	assign file_wr_addr = file_wr_addr_q;
	assign file_wr_data = file_wr_data_q;
	assign z_wr_en = z_wr_en_q;
	assign z_value = z_value_q;
	assign pc_load = pc_load_q;
	assign pc_target = pc_target_q;
	assign discard_active = (state_q == ST_FLUSH); // see RQ6
endmodule // byte_op_branch_execute

// file: tb/byte_op_branch_execute_asserts.sv
`timescale 1ns/10ps
module byte_op_branch_execute_asserts import exec_pkg::*; (
	input logic clock,
	input logic rst_b,
	input logic instr_valid,
	input logic [11:0] instr,
	input logic [7:0] status_in,
	input logic [7:0] w_out,
	input logic file_wr_en,
	input logic z_wr_en,
	input logic z_value,
	input logic pc_load,
	input logic [10:0] pc_target,
	input logic discard_active
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire tk = instr_valid && !discard_active;
	wire jmp = tk && (instr & MASK_JUMP) == CODE_JUMP;
	wire orr = tk && (instr & MASK_LIT) == CODE_IOR;
	wire skp = tk && ((instr & MASK_FILE_D) == CODE_DECSZ || (instr & MASK_FILE_D) == CODE_INCSZ);
	sequence s_flush;
		discard_active ##1 !discard_active;
	endsequence
	a_clear_sets_z: assert property (tk && (instr & MASK_FILE) == CODE_CLR |=> file_wr_en && z_wr_en && z_value)
		else $error("clr");
	a_jump_target: assert property (jmp |=> pc_load && pc_target == {$past(status_in[6:5]), $past(instr[8:0])})
		else $error("jmp");
	a_jump_flush: assert property (jmp |=> s_flush and !z_wr_en) else $error("flush");
	a_skip_no_z: assert property (skp |=> !z_wr_en) else $error("skip");
	a_flush_quiet: assert property (discard_active |=> !file_wr_en && !z_wr_en && !pc_load && $stable(w_out))
		else $error("quiet");
	a_or_result: assert property (orr |=> w_out == ($past(w_out) | $past(instr[7:0])) && z_wr_en
		&& z_value == (w_out == 8'h00)) else $error("or");
	a_one_cycle: assert property (tk && !jmp && !skp |=> !discard_active) else $error("one");
	a_flush_cause: assert property ($rose(discard_active) |-> $past(jmp || skp)) else $error("cause");
endmodule // byte_op_branch_execute_asserts

bind byte_op_branch_execute byte_op_branch_execute_asserts i_chk (.clock, .rst_b, .instr_valid, .instr,
	.status_in, .w_out, .file_wr_en, .z_wr_en, .z_value, .pc_load, .pc_target, .discard_active);

// file: tb/file_space_model.sv
`timescale 1ns/10ps
module file_space_model (
	input logic clock,
	input logic [4:0] ra,
	output logic [7:0] rd,
	input logic we,
	input logic [4:0] wa,
	input logic [7:0] wd
);
	logic [7:0] mem [32];
	assign rd = mem[ra];
	always @(posedge clock) begin
		if (we) begin
			mem[wa] <= wd;
		end
	end
endmodule // file_space_model

// file: tb/byte_op_branch_execute_tb_top.sv
`timescale 1ns/10ps
module byte_op_branch_execute_tb_top import exec_pkg::*; ;
	logic clock = 1'b0, rst_b = 1'b0, iv = 1'b0;
	logic [11:0] ins = 12'h000;
	logic [7:0] st = 8'h00;
	logic [4:0] ra, wa;
	logic [7:0] rd, w, wd;
	logic we, ze, zv, pl, da;
	logic [10:0] pt;
	int bad_count = 0, samples_checked = 0;
	always #5 clock = ~clock;
	byte_op_branch_execute i_dut (.clock(clock), .rst_b(rst_b), .instr_valid(iv), .instr(ins),
		.file_rd_addr(ra), .file_rd_data(rd), .status_in(st), .w_out(w), .file_wr_en(we),
		.file_wr_addr(wa), .file_wr_data(wd), .z_wr_en(ze), .z_value(zv), .pc_load(pl),
		.pc_target(pt), .discard_active(da));
	file_space_model i_mem (.clock, .ra, .rd, .we, .wa, .wd);
	task chk(string n, logic [19:0] s, e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s word %h exp %h got %h", n, ins, e, s);
		end
	endtask
	// Seen value: flags {discard, write, zero write, zero}, then write data, then W
	task op(logic [11:0] x, logic [7:0] f, logic v, logic [19:0] e);
		i_mem.mem[x[4:0]] = f;
		@(negedge clock);
		ins = x;
		iv = 1'b1;
		@(negedge clock);
		iv = v;
		chk("out", {da, we, ze, zv, wd, w}, e);
	endtask
	task t_file;
		op(CODE_CLR | 12'h004, 8'h55, 1'b0, 20'h70000);
		op(CODE_INC | 12'h023, 8'h7f, 1'b0, 20'h68000);
		chk("addr", {15'h0000, wa}, 20'h00003);
		op(CODE_DEC | 12'h026, 8'h00, 1'b0, 20'h6ff00);
		op(CODE_COM | 12'h005, 8'hff, 1'b0, 20'h3ff00);
		op(CODE_INC | 12'h009, 8'h80, 1'b0, 20'h2ff81);
	endtask
	task t_skip;
		op(CODE_DECSZ | 12'h022, 8'h01, 1'b1, 20'hc0081);
		@(negedge clock);
		iv = 1'b0;
		chk("drop", {da, we, ze, zv, wd, w}, 20'h00081);
		op(CODE_INCSZ | 12'h007, 8'hff, 1'b0, 20'h80000);
		op(CODE_INCSZ | 12'h028, 8'h04, 1'b0, 20'h40500);
	endtask
	task t_jump;
		st = 8'h60;
		op(CODE_JUMP | 12'h123, 8'h00, 1'b0, 20'h80500);
		chk("pc", {pl, pt}, 20'h00f23);
	endtask
	task t_or;
		op(CODE_IOR, 8'h00, 1'b0, 20'h30500);
		op(CODE_IOR | 12'h0a5, 8'h00, 1'b0, 20'h205a5);
		op(12'h044, 8'h33, 1'b0, 20'h005a5);
	endtask
	task t_reset;
		@(negedge clock);
		rst_b = 1'b0;
		@(negedge clock);
		chk("rst out", {da, we, ze, zv, wd, w}, 20'h00000);
		chk("rst pc", {pl, pt}, 20'h00000);
		chk("rst addr", {15'h0000, wa}, 20'h00000);
		rst_b = 1'b1;
		op(CODE_INC | 12'h00a, 8'h41, 1'b0, 20'h20042);
	endtask
	task tally_and_finish;
		$display("%0d checks %0d errors", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clock);
		rst_b = 1'b1;
		t_file;
		t_skip;
		t_jump;
		t_or;
		t_reset;
		tally_and_finish;
	end
endmodule // byte_op_branch_execute_tb_top
